/* File: logic/serial_switch_consts.svh */
// constant values shared by the secure ic serial switch files
`ifndef SERIAL_SWITCH_CONSTS_SVH
`define SERIAL_SWITCH_CONSTS_SVH
// =====================================================================
// route codes
`define TX_ROUTE_NONE 2'h0
`define TX_ROUTE_CODER 2'h1
`define TX_ROUTE_NFCF 2'h2
`define TX_ROUTE_MILLER 2'h3
`define RX_ROUTE_DEMOD 1'h0
`define RX_ROUTE_SECURE 1'h1
`define CLK_SEL_OSC 1'h0
`define CLK_SEL_FIELD 1'h1
// =====================================================================
// timing in carrier cycles
`define HALF_BIT_212 6'h20
`define FILTER_DEPTH_DEF 4
`define LOCK_EDGES_DEF 16
`define RATE_424_MAX 8'h18
`define RATE_212_MAX 8'h30
`define RATE_106 2'h0
`define RATE_212 2'h1
`define RATE_424 2'h2
`endif

/* File: logic/serial_switch_pkg.sv */
// types shared by the secure ic serial switch modules
`default_nettype none
`include "serial_switch_consts.svh"
package serial_switch_pkg;
  // =====================================================================
  // configuration and results
  typedef struct packed {
    logic [1:0] txRouteSelect;
    logic rxRouteSelect;
    logic driverMixSel;
    logic loadModExternal;
    logic auxClockPinEnable;
    logic secureClockSel;
    logic receiverOff;
    logic modeDetectDisable;
  } switchCfg_t;

  typedef struct packed {
    logic locked;
    logic syncSeen;
    logic [1:0] rate;
  } modeResult_t;

  // =====================================================================
  // link states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PREAMBLE = 3'h2,
    ST_RELAY = 3'h4
  } linkState_t;

  typedef struct packed {
    logic [1:0] oscSync;
    logic [1:0] fieldClkSync;
    logic [1:0] fieldDetSync;
    logic [1:0] demodSync;
    logic [1:0] rxSync;
    logic carrierLevel;
    logic rxSampled;
    logic prevFilt;
    linkState_t link;
    logic [5:0] preCnt;
    logic preHalf;
    logic secureTxOut;
    logic antennaDriveA;
    logic antennaDriveB;
    logic loadModOut;
    logic auxSecureClockPin;
    logic decoderOut;
    logic wiredNfcFReady;
    logic preambleActive;
  } switchState_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] minW;
    logic [4:0] edges;
    logic prev;
    modeResult_t res;
  } detState_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic dout;
  } filtState_t;
endpackage
`default_nettype wire

/* File: logic/spike_filter.sv */
// spike filter for the demodulated or wired coder stream, sampled on carrier rising edges
`default_nettype none
`include "serial_switch_consts.svh"
module spike_filter #(
  parameter int DEPTH = `FILTER_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sampleEn,
  input wire logic din,
  output logic dout
);
  import serial_switch_pkg::*;
  filtState_t st, next_st;

  // depth must fit the counter and stay well under one bit
  if (DEPTH < 1 || DEPTH > 15) begin : gDepthCheck
    $error("spike_filter DEPTH out of range");
  end

  // =====================================================================
  // level must hold DEPTH carrier edges before the output follows
  always_comb begin
    next_st = st;
    if (sampleEn) begin
      if (din == st.dout) begin
        next_st.cnt = 4'h0;
      end else if (st.cnt == 4'(DEPTH - 1)) begin
        next_st.cnt = 4'h0;
        next_st.dout = din; // [R9]
      end else begin
        next_st.cnt = st.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.dout;

  AST_FILT_ON_EDGE: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    (st.dout != $past(st.dout)) |-> $past(sampleEn))
    else $error("filtered data moved without a carrier edge");
endmodule
`default_nettype wire

/* File: logic/mode_detector.sv */
// data mode detector: rate lock and sync detection on the receive stream
`default_nettype none
`include "serial_switch_consts.svh"
module mode_detector #(
  parameter int LOCK_EDGES = `LOCK_EDGES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic fieldPresent,
  input wire logic carrierRise,
  input wire logic dataIn,
  output serial_switch_pkg::modeResult_t result
);
  import serial_switch_pkg::*;
  detState_t st, next_st;
  logic [8:0] twiceW;
  logic [9:0] triMin;

  if (LOCK_EDGES < 2 || LOCK_EDGES > 31) begin : gLockCheck
    $error("mode_detector LOCK_EDGES out of range");
  end

  // shortest interval tells the rate; 106k is the iso 14443a scheme
  function automatic logic [1:0] rateOf(input logic [7:0] w);
    rateOf = (w < `RATE_424_MAX) ? `RATE_424 : (w < `RATE_212_MAX) ? `RATE_212 : `RATE_106;
  endfunction

  // =====================================================================
  // interval measurement between data edges, in carrier cycles
  always_comb begin
    next_st = st;
    twiceW = {st.cnt, 1'b0};
    triMin = 10'(st.minW) * 10'h3;
    if (!enable || !fieldPresent) begin
      next_st = '0; // [R19] [R20]
      next_st.minW = 8'hff;
    end else if (carrierRise) begin
      next_st.cnt = (st.cnt == 8'hff) ? st.cnt : st.cnt + 8'h1;
      if (dataIn != st.prev) begin
        next_st.prev = dataIn;
        next_st.cnt = 8'h1;
        if (!st.res.locked) begin
          next_st.edges = st.edges + 5'h1;
          // the first edge has no earlier edge, so its count is no interval
          if (st.edges != 5'h0 && st.cnt < st.minW) begin
            next_st.minW = st.cnt;
          end
          if (st.edges == 5'(LOCK_EDGES - 1)) begin
            next_st.res.locked = 1'b1;
            next_st.res.rate = rateOf(st.minW); // [R18]
          end
        end else if (10'(twiceW) >= triMin) begin
          // a full-bit interval after the all-zero preamble marks sync
          next_st.res.syncSeen = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign result = st.res;

  AST_DET_CLEAR: assert property (@(posedge clk) disable iff (!nrst) // [R19]
    (!fieldPresent || !enable) |=> !result.locked && !result.syncSeen)
    else $error("mode detector not cleared while idle");
endmodule
`default_nettype wire

/* File: logic/secure_ic_serial_switch.sv */
// serial data switch between coder logic, antenna front end and secure ic
//
// Behaviour
// [R1] Switch routes coder/decoder signals to antenna side or secure ic pins.
// [R2] Secure input takes fast signalling; output carries any coder rate.
// [R3] Load modulation normally on antenna drivers, optionally on external pin.
// [R4] Driver mix set: secure input and coder both drive antenna.
// [R5] Secure ic sends digital NFC-F or ISO 14443A signal on input.
// [R6] Wired card: internal oscillator clocks link, device drives output line.
// [R7] Virtual card: output and clock derived from external reader field.
// [R8] NFC-F output is carrier xor filtered demodulated data; in wired mode the filter is fed coderIn instead.
// [R9] Demodulated data filtered against spikes, delay under one bit.
// [R10] Filtered data changes only on carrier rising edge.
// [R11] NFC-F card emulation sends 212k preamble once field detected.
// [R12] With detector on, received-rate data follows only after sync.
// [R13] Secure element return synchronous to output bit clock, modulo four.
// [R14] NFC-F wired card needs receiver off set.
// [R15] NFC-F secure response passes straight to antenna driver.
// [R16] Aux pin carries carrier clock when its enable is set.
// [R17] Secure input and output share one clock.
// [R18] Mode detector recognises scheme and rate, prepares receiver.
// [R19] Detector runs only during anticollision, cleared without field.
// [R20] Detect disable keeps detector off during anticollision.
// [R21] ISO 14443A route sends Miller signal, expects Manchester return.
// [R22] No output route selected: secure output held low.
`default_nettype none
`include "serial_switch_consts.svh"
module secure_ic_serial_switch #(
  parameter int FILTER_DEPTH = `FILTER_DEPTH_DEF,
  parameter int LOCK_EDGES = `LOCK_EDGES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic oscClkIn,
  input wire logic fieldClkIn,
  input wire logic rfFieldDetected,
  input wire logic autoCollActive,
  input wire logic demodIn,
  input wire logic coderIn,
  input wire logic millerIn,
  input wire logic secureRxIn,
  input wire serial_switch_pkg::switchCfg_t cfg,
  output logic secureTxOut,
  output logic antennaDriveA,
  output logic antennaDriveB,
  output logic loadModOut,
  output logic auxSecureClockPin,
  output logic decoderOut,
  output logic wiredNfcFReady,
  output logic preambleActive,
  output serial_switch_pkg::modeResult_t modeResult
);
  import serial_switch_pkg::*;

  switchState_t st, next_st;
  logic selClk;
  logic carrierRise;
  logic fieldOn;
  logic wiredMode;
  logic nfcfVirtual;
  logic detEnable;
  logic filtIn;
  logic filtered;
  logic filtEdge;
  logic nfcfData;
  logic driveSrc;

  // =====================================================================
  // helper blocks
  // filter and detector both step on carrier rising edges only
  spike_filter #(
    .DEPTH(FILTER_DEPTH)
  ) uFilter (
    .clk(clk),
    .nrst(nrst),
    .sampleEn(carrierRise),
    .din(filtIn),
    .dout(filtered)
  );

  mode_detector #(
    .LOCK_EDGES(LOCK_EDGES)
  ) uDetector (
    .clk(clk),
    .nrst(nrst),
    .enable(detEnable),
    .fieldPresent(fieldOn),
    .carrierRise(carrierRise),
    .dataIn(filtered),
    .result(modeResult)
  );

  // =====================================================================
  // clock source and mode decode
  always_comb begin
    // wired card uses the oscillator, virtual card the field clock
    selClk = (cfg.secureClockSel == `CLK_SEL_FIELD) ? st.fieldClkSync[1] : st.oscSync[1]; // [R6] [R7]
    carrierRise = selClk & ~st.carrierLevel;
    fieldOn = st.fieldDetSync[1];
    wiredMode = (cfg.secureClockSel == `CLK_SEL_OSC);
    nfcfVirtual = (cfg.txRouteSelect == `TX_ROUTE_NFCF) && !wiredMode;
    detEnable = autoCollActive & ~cfg.modeDetectDisable; // [R19] [R20]
    // wired card feeds the host coder, virtual card the demodulator
    filtIn = wiredMode ? coderIn : st.demodSync[1];
    filtEdge = filtered ^ st.prevFilt;
  end

  // =====================================================================
  // next state
  always_comb begin
    next_st = st;

    // two-stage synchronisers for both foreign clocks and the field detect, demod and secure input pins
    next_st.oscSync = {st.oscSync[0], oscClkIn};
    next_st.fieldClkSync = {st.fieldClkSync[0], fieldClkIn};
    next_st.fieldDetSync = {st.fieldDetSync[0], rfFieldDetected};
    next_st.demodSync = {st.demodSync[0], demodIn};
    next_st.rxSync = {st.rxSync[0], secureRxIn}; // [R2]
    next_st.carrierLevel = selClk;
    next_st.prevFilt = filtered;

    // secure input sampled by the same carrier that clocks the output
    if (carrierRise) begin
      next_st.rxSampled = st.rxSync[1]; // [R17] [R13]
    end

    // card emulation link sequence
    case (st.link)
      ST_IDLE: begin
        next_st.preCnt = 6'h0;
        next_st.preHalf = 1'b0;
        if (nfcfVirtual && fieldOn) begin
          next_st.link = ST_PREAMBLE; // [R11]
        end
      end
      ST_PREAMBLE: begin
        if (!nfcfVirtual || !fieldOn) begin
          next_st.link = ST_IDLE;
        end else begin
          // zero bits at 212k: one half-bit toggle per 32 carrier cycles
          if (carrierRise) begin
            if (st.preCnt == 6'(`HALF_BIT_212 - 6'h1)) begin
              next_st.preCnt = 6'h0;
              next_st.preHalf = ~st.preHalf; // [R11]
            end else begin
              next_st.preCnt = st.preCnt + 6'h1;
            end
          end
          // detector on: wait for sync; off: go on first received edge
          if (detEnable ? modeResult.syncSeen : filtEdge) begin
            next_st.link = ST_RELAY; // [R12]
          end
        end
      end
      ST_RELAY: begin
        if (!nfcfVirtual || !fieldOn) begin
          next_st.link = ST_IDLE;
        end
      end
      default: begin
        next_st.link = ST_IDLE;
      end
    endcase
    next_st.preambleActive = (next_st.link == ST_PREAMBLE);

    // NFC-F data: preamble, relayed demod, or wired coder stream
    if (st.link == ST_PREAMBLE) begin
      nfcfData = st.preHalf;
    end else if (wiredMode || st.link == ST_RELAY) begin
      nfcfData = filtered; // [R9]
    end else begin
      nfcfData = 1'b0;
    end

    // secure output routing
    case (cfg.txRouteSelect)
      `TX_ROUTE_NONE: begin
        next_st.secureTxOut = 1'b0; // [R22]
      end
      `TX_ROUTE_CODER: begin
        next_st.secureTxOut = coderIn; // [R1] [R2]
      end
      `TX_ROUTE_NFCF: begin
        next_st.secureTxOut = st.carrierLevel ^ nfcfData; // [R8]
      end
      `TX_ROUTE_MILLER: begin
        next_st.secureTxOut = millerIn; // [R21]
      end
      default: begin
        next_st.secureTxOut = 1'b0;
      end
    endcase

    // antenna driver source: coder, secure response, or both mixed
    if (cfg.driverMixSel) begin
      driveSrc = coderIn | st.rxSampled; // [R4]
    end else if (cfg.rxRouteSelect == `RX_ROUTE_SECURE) begin
      driveSrc = st.rxSampled; // [R15]
    end else begin
      driveSrc = coderIn; // [R1]
    end

    // external load modulation takes the source off the drivers
    if (cfg.loadModExternal) begin
      next_st.loadModOut = driveSrc; // [R3]
      next_st.antennaDriveA = 1'b0;
      next_st.antennaDriveB = 1'b0;
    end else begin
      next_st.loadModOut = 1'b0;
      next_st.antennaDriveA = driveSrc; // [R3]
      next_st.antennaDriveB = driveSrc;
    end

    // decoder input: secure return, or demodulator gated by receiver off
    if (cfg.rxRouteSelect == `RX_ROUTE_SECURE) begin
      next_st.decoderOut = st.rxSampled; // [R21] [R5]
    end else if (cfg.receiverOff) begin
      next_st.decoderOut = 1'b0; // [R14]
    end else begin
      next_st.decoderOut = st.demodSync[1];
    end

    // wired NFC-F is only usable with the receiver switched off
    next_st.wiredNfcFReady = wiredMode && (cfg.txRouteSelect == `TX_ROUTE_NFCF) &&
      cfg.receiverOff; // [R14]

    // aux pin mirrors the selected carrier
    next_st.auxSecureClockPin = cfg.auxClockPinEnable & st.carrierLevel; // [R16]
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.link <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign secureTxOut = st.secureTxOut;
  assign antennaDriveA = st.antennaDriveA;
  assign antennaDriveB = st.antennaDriveB;
  assign loadModOut = st.loadModOut;
  assign auxSecureClockPin = st.auxSecureClockPin;
  assign decoderOut = st.decoderOut;
  assign wiredNfcFReady = st.wiredNfcFReady;
  assign preambleActive = st.preambleActive;

  // =====================================================================
  // checks
  AST_TX_QUIET: assert property (@(posedge clk) disable iff (!nrst) // [R22]
    (cfg.txRouteSelect == `TX_ROUTE_NONE) |=> !secureTxOut)
    else $error("secure output active with no route");

  AST_MILLER_ROUTE: assert property (@(posedge clk) disable iff (!nrst) // [R21]
    (cfg.txRouteSelect == `TX_ROUTE_MILLER) |=> (secureTxOut == $past(millerIn)))
    else $error("miller route not on secure output");

  AST_AUX_OFF: assert property (@(posedge clk) disable iff (!nrst) // [R16]
    (!cfg.auxClockPinEnable ##1 !cfg.auxClockPinEnable) |=> !auxSecureClockPin)
    else $error("aux clock pin toggles while disabled");

  AST_RCV_OFF: assert property (@(posedge clk) disable iff (!nrst) // [R14]
    (cfg.rxRouteSelect == `RX_ROUTE_DEMOD && cfg.receiverOff) |=> !decoderOut)
    else $error("decoder fed while receiver off");

  AST_MIX: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (cfg.driverMixSel && !cfg.loadModExternal && (coderIn || st.rxSampled))
      |=> antennaDriveA && antennaDriveB)
    else $error("mixed driver source lost");

  AST_LOADMOD: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    cfg.loadModExternal |=> !antennaDriveA && !antennaDriveB)
    else $error("antenna driven during external load modulation");

  AST_PRE_START: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    (st.link == ST_IDLE && nfcfVirtual && fieldOn) |=> preambleActive)
    else $error("preamble not started on field");

  AST_NO_FIELD: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    !fieldOn |=> (st.link == ST_IDLE))
    else $error("link active without field");

  AST_WAIT_SYNC: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    (st.link == ST_PREAMBLE && detEnable && !modeResult.syncSeen) |=> (st.link != ST_RELAY))
    else $error("relay started before sync");

  AST_PRE_RATE: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    (st.link == ST_PREAMBLE && carrierRise && st.preCnt != 6'(`HALF_BIT_212 - 6'h1))
      |=> $stable(st.preHalf))
    else $error("preamble half bit too short");

  AST_CODER_ROUTE: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    (cfg.txRouteSelect == `TX_ROUTE_CODER) |=> (secureTxOut == $past(coderIn)))
    else $error("coder route not on secure output");

  AST_WIRED_XOR: assert property (@(posedge clk) disable iff (!nrst) // [R8] [R6]
    (cfg.txRouteSelect == `TX_ROUTE_NFCF && wiredMode && st.link == ST_IDLE)
      |=> (secureTxOut == ($past(st.carrierLevel) ^ $past(filtered))))
    else $error("wired output is not carrier xor filtered data");

  AST_PRE_SHAPE: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    (cfg.txRouteSelect == `TX_ROUTE_NFCF && st.link == ST_PREAMBLE)
      |=> (secureTxOut == ($past(st.carrierLevel) ^ $past(st.preHalf))))
    else $error("preamble not carried on secure output");

  AST_RELAY_DATA: assert property (@(posedge clk) disable iff (!nrst) // [R12] [R7]
    (cfg.txRouteSelect == `TX_ROUTE_NFCF && st.link == ST_RELAY)
      |=> (secureTxOut == ($past(st.carrierLevel) ^ $past(filtered))))
    else $error("relayed data not carried on secure output");

  AST_AUX_ON: assert property (@(posedge clk) disable iff (!nrst) // [R16]
    cfg.auxClockPinEnable |=> (auxSecureClockPin == $past(st.carrierLevel)))
    else $error("aux pin does not follow the carrier");

  AST_DRIVE_PAIR: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    antennaDriveA == antennaDriveB)
    else $error("antenna driver pair split");

  AST_LOADMOD_OFF: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    !cfg.loadModExternal |=> !loadModOut)
    else $error("load modulation pin active while internal");

  AST_SECURE_RESP: assert property (@(posedge clk) disable iff (!nrst) // [R15]
    (!cfg.driverMixSel && cfg.rxRouteSelect == `RX_ROUTE_SECURE && !cfg.loadModExternal)
      |=> (antennaDriveA == $past(st.rxSampled)))
    else $error("secure response not on antenna drivers");

  AST_RX_SAMPLE: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    !carrierRise |=> $stable(st.rxSampled))
    else $error("secure input sampled off the carrier edge");

  AST_READY: assert property (@(posedge clk) disable iff (!nrst) // [R14]
    wiredNfcFReady |-> $past(cfg.receiverOff))
    else $error("wired ready without receiver off");

  AST_DECODER_RX: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    (cfg.rxRouteSelect == `RX_ROUTE_SECURE) |=> (decoderOut == $past(st.rxSampled)))
    else $error("secure return not on decoder");
endmodule
`default_nettype wire

/* File: bench/secure_ic_model.sv */
// behavioural secure element on the two-wire link
`default_nettype none
module secure_ic_model (
  input wire logic carrier,
  input wire logic active,
  input wire logic txBit,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // return line
  // launched on carrier rise so the shared clock always sees settled bits
  initial rxLine = 1'b0;
  always @(posedge carrier) begin
    if (active) begin
      rxLine <= txBit;
    end else begin
      rxLine <= ~rxLine; // released line never shows a stale level
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the secure ic serial switch
`default_nettype none
`include "serial_switch_consts.svh"
module tb;
  import serial_switch_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FDEPTH = 4;
  localparam int LOCKN = 4;
  logic clk, nrst, oscClkIn, fieldClkIn, rfFieldDetected, autoCollActive;
  logic demodIn, coderIn, millerIn, secureRxIn, seActive, seBit;
  switchCfg_t cfg;
  logic secureTxOut, antennaDriveA, antennaDriveB, loadModOut, auxSecureClockPin;
  logic decoderOut, wiredNfcFReady, preambleActive;
  modeResult_t modeResult;
  int err_total, n_tests, auxHi, txHi, same;
  int halfTab[3] = '{16, 64, 32};
  logic [1:0] rateTab[3] = '{`RATE_424, `RATE_106, `RATE_212};

  secure_ic_serial_switch #(.FILTER_DEPTH(FDEPTH), .LOCK_EDGES(LOCKN)) i_dut (
    .clk(clk), .nrst(nrst), .oscClkIn(oscClkIn), .fieldClkIn(fieldClkIn),
    .rfFieldDetected(rfFieldDetected), .autoCollActive(autoCollActive),
    .demodIn(demodIn), .coderIn(coderIn), .millerIn(millerIn), .secureRxIn(secureRxIn),
    .cfg(cfg), .secureTxOut(secureTxOut), .antennaDriveA(antennaDriveA),
    .antennaDriveB(antennaDriveB), .loadModOut(loadModOut),
    .auxSecureClockPin(auxSecureClockPin), .decoderOut(decoderOut),
    .wiredNfcFReady(wiredNfcFReady), .preambleActive(preambleActive),
    .modeResult(modeResult)
  );

  // secure element clocked by the oscillator, as in wired operation
  secure_ic_model i_se (
    .carrier(oscClkIn), .active(seActive), .txBit(seBit), .rxLine(secureRxIn)
  );

  // =====================================================================
  // clocks: system, free oscillator, field carrier only while field present
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    oscClkIn = 1'b0;
    #7;
    forever #160 oscClkIn = ~oscClkIn;
  end
  initial begin
    fieldClkIn = 1'b0;
    #53;
    forever begin
      #160;
      fieldClkIn = rfFieldDetected ? ~fieldClkIn : 1'b0;
    end
  end

  // =====================================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts levels over a window; same = output matches the carrier copy
  task automatic watch(input int n);
    auxHi = 0;
    txHi = 0;
    same = 0;
    repeat (n) begin
      tick(1);
      auxHi += (auxSecureClockPin === 1'b1);
      txHi += (secureTxOut === 1'b1);
      same += (secureTxOut === auxSecureClockPin);
    end
  endtask

  // demod toggles, hc clk cycles apart (8 clk per carrier period)
  task automatic demodEdges(input int n, input int hc);
    repeat (n) begin
      demodIn = ~demodIn;
      tick(hc);
    end
  endtask

  task automatic fieldCycle();
    rfFieldDetected = 1'b0;
    tick(10);
    chk({7'h0, modeResult.locked}, 8'h0);
    rfFieldDetected = 1'b1;
    tick(10);
  endtask

  task end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog sized well above the expected 10k cycles
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end

  // =====================================================================
  // main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    nrst = 1'b0;
    {rfFieldDetected, autoCollActive, demodIn, coderIn, millerIn, seActive, seBit} = '0;
    cfg = '0;
    tick(8);
    nrst = 1'b1;
    tick(1);
    chk({secureTxOut, antennaDriveA, antennaDriveB, loadModOut, auxSecureClockPin,
         decoderOut, wiredNfcFReady, preambleActive}, 8'h0);
    // route none, aux pin off then on
    watch(40);
    chk({7'h0, auxHi == 0}, 8'h1);
    chk({7'h0, txHi == 0}, 8'h1);
    cfg.auxClockPinEnable = 1'b1;
    tick(10);
    watch(40);
    chk({7'h0, auxHi > 8 && auxHi < 32}, 8'h1);
    chk({7'h0, txHi == 0}, 8'h1);
    // ready flag over clock source, route and receiver-off combinations
    for (int i = 0; i < 8; i++) begin
      cfg.secureClockSel = i[0];
      cfg.txRouteSelect = i[1] ? `TX_ROUTE_NFCF : `TX_ROUTE_CODER;
      cfg.receiverOff = i[2];
      tick(3);
      chk({7'h0, wiredNfcFReady}, {7'h0, i == 6});
    end
    // wired nfc-f: output is carrier xor filtered data
    cfg.secureClockSel = `CLK_SEL_OSC;
    cfg.txRouteSelect = `TX_ROUTE_NFCF;
    tick(80);
    watch(64);
    chk({7'h0, same > 48}, 8'h1);
    coderIn = 1'b1;
    tick(80);
    watch(64);
    chk({7'h0, same < 16}, 8'h1);
    coderIn = 1'b0;
    tick(80);
    coderIn = 1'b1;
    tick(8);
    coderIn = 1'b0;
    watch(64);
    chk({7'h0, same > 48}, 8'h1);
    // antenna drive mixing and load-modulation routing
    cfg.txRouteSelect = `TX_ROUTE_CODER;
    cfg.driverMixSel = 1'b1;
    seActive = 1'b1;
    seBit = 1'b1;
    tick(30);
    chk({6'h0, antennaDriveA, antennaDriveB}, 8'h3);
    cfg.driverMixSel = 1'b0;
    tick(30);
    chk({6'h0, antennaDriveA, antennaDriveB}, 8'h0);
    coderIn = 1'b1;
    tick(5);
    chk({6'h0, antennaDriveA, antennaDriveB}, 8'h3);
    chk({7'h0, secureTxOut}, 8'h1);
    cfg.loadModExternal = 1'b1;
    tick(5);
    chk({5'h0, antennaDriveA, antennaDriveB, loadModOut}, 8'h1);
    cfg.loadModExternal = 1'b0;
    coderIn = 1'b0;
    // miller stream on the secure output
    cfg.txRouteSelect = `TX_ROUTE_MILLER;
    millerIn = 1'b1;
    tick(2);
    chk({7'h0, secureTxOut}, 8'h1);
    millerIn = 1'b0;
    tick(2);
    chk({7'h0, secureTxOut}, 8'h0);
    // receive routing towards the decoder
    cfg.rxRouteSelect = `RX_ROUTE_SECURE;
    tick(30);
    chk({7'h0, decoderOut}, 8'h1);
    chk({6'h0, antennaDriveA, antennaDriveB}, 8'h3);
    cfg.rxRouteSelect = `RX_ROUTE_DEMOD;
    cfg.receiverOff = 1'b0;
    demodIn = 1'b1;
    tick(10);
    chk({7'h0, decoderOut}, 8'h1);
    cfg.receiverOff = 1'b1;
    tick(5);
    chk({7'h0, decoderOut}, 8'h0);
    demodIn = 1'b0;
    seActive = 1'b0;
    // virtual card: carrier from field only, preamble on field detect
    cfg.secureClockSel = `CLK_SEL_FIELD;
    cfg.txRouteSelect = `TX_ROUTE_NFCF;
    tick(20);
    watch(40);
    chk({7'h0, auxHi == 0}, 8'h1);
    autoCollActive = 1'b1;
    rfFieldDetected = 1'b1;
    tick(6);
    chk({7'h0, preambleActive}, 8'h1);
    // rate lock for each standard rate, field loss clears the detector
    for (int r = 0; r < 3; r++) begin
      fieldCycle();
      demodEdges(LOCKN + 2, halfTab[r] * 8);
      chk({5'h0, modeResult.locked, modeResult.rate}, {5'h0, 1'b1, rateTab[r]});
    end
    // long interval after lock at 212k marks sync, then relay
    demodEdges(2, 512);
    tick(5);
    chk({6'h0, modeResult.syncSeen, preambleActive}, 8'h2);
    rfFieldDetected = 1'b0;
    tick(6);
    chk({7'h0, preambleActive}, 8'h0);
    // detector held off by disable bit, and outside anticollision
    for (int k = 0; k < 2; k++) begin
      cfg.modeDetectDisable = (k == 0);
      autoCollActive = (k == 0);
      fieldCycle();
      demodEdges(LOCKN + 2, 256);
      chk({7'h0, modeResult.locked}, 8'h0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
